// >>> hdl/sar_readout_pkg.sv
// shared constants and types for the converter serial readout ends
package sar_readout_pkg;
  // converter word
  localparam int RESULT_BITS = 16;
  // reference clock period in ns
  localparam int REF_CLK_NS = 8;
  // conversion time window in ns (plain defaults)
  localparam int CONV_MIN_NS = 500;
  localparam int CONV_MAX_NS = 700;
  // least time rounds up, longest time rounds down
  localparam int CONV_MIN_CYCLES = (CONV_MIN_NS + REF_CLK_NS - 1) / REF_CLK_NS;
  localparam int CONV_MAX_CYCLES = CONV_MAX_NS / REF_CLK_NS;
  // host timing
  localparam int HALF_DIV = 8;
  localparam int SETUP_CYCLES = 4;
  localparam int WAIT_MARGIN = 4;
  // reset values
  localparam logic [4:0] FALL_RESET = 5'h00;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  // conversion engine states
  typedef enum logic [2:0] {
    CONV_IDLE = 3'b001,
    CONV_RUN  = 3'b010,
    CONV_ACQ  = 3'b100
  } conv_state_type;
  // readout modes chosen by the host
  typedef enum logic [3:0] {
    MODE_CS_PLAIN    = 4'b0001,
    MODE_CS_BUSY     = 4'b0010,
    MODE_CHAIN_PLAIN = 4'b0100,
    MODE_CHAIN_BUSY  = 4'b1000
  } mode_type;
  // host sequencer states
  typedef enum logic [5:0] {
    H_IDLE  = 6'b000001,
    H_SETUP = 6'b000010,
    H_CONV  = 6'b000100,
    H_GAP   = 6'b001000,
    H_READ  = 6'b010000,
    H_END   = 6'b100000
  } host_state_type;
endpackage

// >>> hdl/sar_link_if.sv
// four-pin serial link between converter and host
`timescale 1ns/1ns
`default_nettype none
interface sar_link_if;
  logic convertStart;
  logic serialInSelect;
  logic serialClk;
  logic serialOut;
  logic serialOutEnN;
  wire logic serialLine;
  // pull-up resolves the released output to high
  assign serialLine = serialOutEnN ? 1'b1 : serialOut;
  modport adc (
    input  convertStart,
    input  serialInSelect,
    input  serialClk,
    output serialOut,
    output serialOutEnN
  );
  modport host (
    output convertStart,
    output serialInSelect,
    output serialClk,
    input  serialLine
  );
endinterface
`default_nettype wire

// >>> hdl/sar_adc_end.sv
// converter end: conversion trigger, mode capture and serial readout
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1: convert-start rise latches select level as mode
// R2: select low after conversion presents the MSB
// R3: later bits shift out on serial-clock falls
// R4: plain select mode releases after 16 falls
// R5: select high plus rise: convert, high impedance
// R6: host keeps convert-start high through readback
// R7: select and convert-start low drive output low
// R8: host holds select low across conversion
// R9: busy select mode drives low at completion
// R10: busy bit then data, release after 17
// R11: completion enters acquisition, core powered down
// R12: clock low at rise: chain, no busy
// R13: plain chain shows MSB at completion
// R14: chain shifts select input through on falls
// R15: host gives sixteen clocks per chained device
// R16: clock high at rise: chain with busy
// R17: busy high only when whole chain done
// R18: host gives sixteen per device plus one
// R19: host holds convert-start high in chain readback
// R20: fixed internal conversion time, start ignored meanwhile
module sar_adc_end #(
  parameter int CONV_NS    = 600,
  parameter bit CHAIN_HEAD = 1'b1
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // pins toward the host
  sar_link_if.adc          link,
  // user side
  input  wire logic [15:0] sampleValue,
  output logic             corePowered,
  output logic             resultReady
);
  localparam int CONV_CYCLES = (CONV_NS + sar_readout_pkg::REF_CLK_NS - 1)
                               / sar_readout_pkg::REF_CLK_NS;
  localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);
  localparam logic [4:0] WORD_FALLS = 5'(sar_readout_pkg::RESULT_BITS);
  localparam logic [4:0] FALL_SAT = 5'(sar_readout_pkg::RESULT_BITS + 1);

  sar_readout_pkg::conv_state_type state;
  logic        cnvMeta;
  logic        cnvSync;
  logic        cnvPrev;
  logic        sdiMeta;
  logic        sdiSync;
  logic        sclkMeta;
  logic        sclkSync;
  logic [15:0] convTimer;
  logic [15:0] result;
  logic        chainMode;
  logic        chainBusy;
  logic        csBusy;
  logic        busyMode;
  logic        linkClear;
  logic [4:0]  fallCount;
  logic [15:0] passReg;
  logic [4:0]  dataPos;
  logic        cnvRise;
  logic        convEnd;
  logic        done;
  logic        idleLow;
  logic        outValue;
  logic        outDrive;
  logic        busyHigh;

  // pin synchronisers, two stages each
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnvMeta  <= 1'b0;
      cnvSync  <= 1'b0;
      cnvPrev  <= 1'b0;
      // select idles high, so a low reset value would fake a drive-low request
      sdiMeta  <= 1'b1;
      sdiSync  <= 1'b1;
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
    end else begin
      cnvMeta  <= link.convertStart;
      cnvSync  <= cnvMeta;
      cnvPrev  <= cnvSync;
      sdiMeta  <= link.serialInSelect;
      sdiSync  <= sdiMeta;
      sclkMeta <= link.serialClk;
      sclkSync <= sclkMeta;
    end
  end

  assign cnvRise = cnvSync & ~cnvPrev;
  assign convEnd = (state == sar_readout_pkg::CONV_RUN) && (convTimer == CONV_LAST);
  assign done    = (state == sar_readout_pkg::CONV_ACQ);

  // conversion engine; start edges are ignored while converting
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state     <= sar_readout_pkg::CONV_IDLE;
      convTimer <= sar_readout_pkg::TIMER_RESET;
    end else begin
      unique case (state)
        sar_readout_pkg::CONV_IDLE, sar_readout_pkg::CONV_ACQ: begin
          convTimer <= sar_readout_pkg::TIMER_RESET;
          if (cnvRise) begin
            state <= sar_readout_pkg::CONV_RUN; // [R5] [R20]
          end
        end
        sar_readout_pkg::CONV_RUN: begin
          convTimer <= convTimer + 16'h0001; // [R20]
          if (convEnd) begin
            state <= sar_readout_pkg::CONV_ACQ; // [R11]
          end
        end
      endcase
    end
  end

  // mode capture at the start edge, sample taken with it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      chainMode <= 1'b0;
      chainBusy <= 1'b0;
      result    <= 16'h0000;
    end else if (cnvRise && state != sar_readout_pkg::CONV_RUN) begin
      chainMode <= ~sdiSync;              // [R1] [R12] [R16]
      chainBusy <= ~sdiSync & sclkSync;   // [R12] [R16]
      result    <= sampleValue;
    end
  end

  // select mode busy bit is armed by select low at completion
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      csBusy <= 1'b0;
    end else if (cnvRise && state != sar_readout_pkg::CONV_RUN) begin
      csBusy <= 1'b0;
    end else if (convEnd) begin
      csBusy <= ~sdiSync; // [R8] [R9]
    end
  end

  assign busyMode = chainMode ? chainBusy : csBusy;

  // holds the link-side counter clear outside a readback window
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      linkClear <= 1'b1;
    end else begin
      linkClear <= ~(done | convEnd) | (~chainMode & sdiSync); // [R4] [R10]
    end
  end

  // link side: count serial-clock falls; the link clock may stand still,
  // so the frame is opened and closed by linkClear from the other domain
  always_ff @(negedge link.serialClk or posedge linkClear) begin
    if (linkClear) begin
      fallCount <= sar_readout_pkg::FALL_RESET;
    end else if (fallCount != FALL_SAT) begin
      fallCount <= fallCount + 5'h01; // [R3]
    end
  end

  // pass-through register: upstream bits enter after the busy slot
  always_ff @(negedge link.serialClk or posedge linkClear) begin
    if (linkClear) begin
      passReg <= 16'h0000;
    end else if (fallCount >= {4'h0, busyMode}) begin
      passReg <= {passReg[14:0], link.serialInSelect}; // [R14]
    end
  end

  assign dataPos  = fallCount - {4'h0, busyMode};
  assign idleLow  = ~cnvSync & ~sdiSync;
  assign busyHigh = CHAIN_HEAD | sdiSync; // upstream ready or chain head

  // output value and drive; mode, result and busy are stable in a frame
  always_comb begin
    outValue = 1'b0;
    outDrive = 1'b0;
    if (idleLow) begin
      outDrive = 1'b1; // [R7]
    end else if (cnvRise && state != sar_readout_pkg::CONV_RUN) begin
      // the start edge applies the new mode at once, not the stale one:
      // select mode floats, chain mode drives low, so no false busy level
      outDrive = ~sdiSync; // [R5] [R12] [R16]
    end else if (chainMode) begin
      outDrive = (state != sar_readout_pkg::CONV_IDLE);
      if (done) begin
        if (busyMode && fallCount == 5'h00) begin
          outValue = busyHigh; // [R17]
        end else if (dataPos < WORD_FALLS) begin
          outValue = result[4'hf - dataPos[3:0]]; // [R13] [R3]
        end else begin
          outValue = passReg[15]; // [R14]
        end
      end
    end else if (done && !sdiSync && fallCount < WORD_FALLS + {4'h0, busyMode}) begin
      outDrive = 1'b1; // [R2] [R9]
      if (!(busyMode && fallCount == 5'h00)) begin
        outValue = result[4'hf - dataPos[3:0]]; // [R2] [R3] [R10]
      end
    end
  end

  // enable is active low; released otherwise, high impedance [R5] [R4] [R10]
  assign link.serialOut    = outValue;
  assign link.serialOutEnN = ~outDrive;

  // user status: core power and result availability
  assign corePowered = (state == sar_readout_pkg::CONV_RUN); // [R11]
  assign resultReady = done;
endmodule
`default_nettype wire

// >>> hdl/sar_host_end.sv
// host end: launches conversions and reads the serial results back
`timescale 1ns/1ns
`default_nettype none
module sar_host_end #(
  parameter int CHAIN_LEN = 1
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // pins toward the converter
  sar_link_if.host                       link,
  // user command side
  input  wire logic                      start,
  input  wire sar_readout_pkg::mode_type modeSel,
  output logic                           ready,
  output logic [15:0]                    wordData,
  output logic                           wordValid,
  output logic                           frameDone
);
  localparam logic [15:0] PLAIN_BITS = 16'(16 * CHAIN_LEN);
  localparam logic [15:0] HALF_LAST = 16'(sar_readout_pkg::HALF_DIV - 1);
  localparam logic [15:0] FULL_LAST = 16'(2 * sar_readout_pkg::HALF_DIV - 1);
  localparam logic [15:0] SETUP_LAST = 16'(sar_readout_pkg::SETUP_CYCLES - 1);
  localparam logic [15:0] WAIT_LAST = 16'(sar_readout_pkg::CONV_MAX_CYCLES
                                          + sar_readout_pkg::WAIT_MARGIN);

  sar_readout_pkg::host_state_type state;
  sar_readout_pkg::mode_type       mode;
  logic        lineMeta;
  logic        lineSync;
  logic        convert_start;
  logic        serial_in_select;
  logic        sclk;
  logic [15:0] timer;
  logic [15:0] bitCount;
  logic [3:0]  wordBit;
  logic [15:0] shiftIn;
  logic        busyOn;
  logic        isCs;
  logic [15:0] totalBits;

  assign isCs      = mode[0] | mode[1];
  assign busyOn    = mode[1] | mode[3];
  assign totalBits = PLAIN_BITS + {15'h0000, busyOn}; // [R15] [R18]

  // data line synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lineMeta <= 1'b1;
      lineSync <= 1'b1;
    end else begin
      lineMeta <= link.serialLine;
      lineSync <= lineMeta;
    end
  end

  // sequencer: launch, wait, clock out, close
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state    <= sar_readout_pkg::H_IDLE;
      mode     <= sar_readout_pkg::MODE_CS_PLAIN;
      convert_start      <= 1'b0;
      serial_in_select      <= 1'b1;
      sclk     <= 1'b0;
      timer    <= sar_readout_pkg::TIMER_RESET;
      bitCount <= 16'h0000;
    end else begin
      timer <= timer + 16'h0001;
      unique case (state)
        sar_readout_pkg::H_IDLE: begin
          timer <= sar_readout_pkg::TIMER_RESET;
          if (start) begin
            mode  <= modeSel;
            serial_in_select   <= modeSel[0] | modeSel[1];
            sclk  <= modeSel[3];
            state <= sar_readout_pkg::H_SETUP;
          end
        end
        sar_readout_pkg::H_SETUP: begin
          if (timer == SETUP_LAST) begin
            convert_start   <= 1'b1; // [R6] [R19]
            timer <= sar_readout_pkg::TIMER_RESET;
            state <= sar_readout_pkg::H_CONV;
          end
        end
        sar_readout_pkg::H_CONV: begin
          if (timer == SETUP_LAST) begin
            sclk <= 1'b0;
            if (mode[1]) begin
              serial_in_select <= 1'b0; // [R8]
            end
          end
          if (timer > SETUP_LAST && busyOn && lineSync == mode[3]) begin
            timer <= sar_readout_pkg::TIMER_RESET;
            state <= sar_readout_pkg::H_GAP;
          end else if (!busyOn && timer == WAIT_LAST) begin
            timer <= sar_readout_pkg::TIMER_RESET;
            state <= sar_readout_pkg::H_GAP;
          end
        end
        sar_readout_pkg::H_GAP: begin
          if (isCs) begin
            serial_in_select <= 1'b0;
          end
          if (timer == FULL_LAST) begin
            timer    <= sar_readout_pkg::TIMER_RESET;
            bitCount <= 16'h0000;
            state    <= sar_readout_pkg::H_READ;
          end
        end
        sar_readout_pkg::H_READ: begin
          if (timer == HALF_LAST) begin
            sclk <= 1'b1;
          end else if (timer == FULL_LAST) begin
            sclk     <= 1'b0;
            timer    <= sar_readout_pkg::TIMER_RESET;
            bitCount <= bitCount + 16'h0001;
            if (bitCount == totalBits - 16'h0001) begin
              state <= sar_readout_pkg::H_END;
            end
          end
        end
        sar_readout_pkg::H_END: begin
          convert_start   <= 1'b0;
          serial_in_select   <= isCs;
          state <= sar_readout_pkg::H_IDLE;
        end
      endcase
    end
  end

  // sample on the rising clock, busy slot skipped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      shiftIn   <= 16'h0000;
      wordBit   <= 4'h0;
      wordData  <= 16'h0000;
      wordValid <= 1'b0;
    end else begin
      wordValid <= 1'b0;
      if (state == sar_readout_pkg::H_GAP) begin
        wordBit <= 4'h0;
      end else if (state == sar_readout_pkg::H_READ && timer == HALF_LAST
                   && !(busyOn && bitCount == 16'h0000)) begin
        shiftIn <= {shiftIn[14:0], lineSync};
        wordBit <= wordBit + 4'h1;
        if (wordBit == 4'hf) begin
          wordData  <= {shiftIn[14:0], lineSync};
          wordValid <= 1'b1;
        end
      end
    end
  end

  // frame completion pulse
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frameDone <= 1'b0;
    end else begin
      frameDone <= (state == sar_readout_pkg::H_END);
    end
  end

  assign ready               = (state == sar_readout_pkg::H_IDLE);
  assign link.convertStart   = convert_start;
  assign link.serialInSelect = serial_in_select;
  assign link.serialClk      = sclk;
endmodule
`default_nettype wire

// >>> sim/sar_readout_props.sv
// assertions on the serial link between the converter end and the host end
`timescale 1ns/1ns
`default_nettype none
module sar_readout_props #(
  parameter int CONV_CYCLES = 75
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // link signals
  input wire logic convertStart,
  input wire logic serialInSelect,
  input wire logic serialClk,
  input wire logic serialOut,
  input wire logic serialOutEnN
);
  localparam int LATE = CONV_CYCLES + 8;
  logic        prevStart;
  logic        prevClk;
  logic        csMode;
  logic        chainBusy;
  logic [11:0] convCnt;
  logic [4:0]  fallCnt;
  wire logic   startRise = convertStart && !prevStart;
  wire logic   clkFall = prevClk && !serialClk;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // edge history of start and serial clock
  always_ff @(posedge ref_clk) begin
    prevStart <= rstn ? convertStart : 1'b0;
    prevClk <= rstn ? serialClk : 1'b0;
  end
  // mode seen at the last start edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      csMode <= 1'b1;
      chainBusy <= 1'b0;
    end else if (startRise) begin
      csMode <= serialInSelect;
      chainBusy <= serialClk;
    end
  end
  // cycles since the start edge, saturating
  always_ff @(posedge ref_clk) begin
    if (!rstn) convCnt <= 12'hfff;
    else if (startRise) convCnt <= 12'h001;
    else if (convCnt != 12'hfff) convCnt <= convCnt + 12'h001;
  end
  // serial clock falls since the start edge
  always_ff @(posedge ref_clk) begin
    if (!rstn || startRise) fallCnt <= 5'h00;
    else if (clkFall && fallCnt != 5'h1f) fallCnt <= fallCnt + 5'h01;
  end
  a_idle_low_drive: assert property (
    (!convertStart && !serialInSelect)[*4] |-> !serialOutEnN && !serialOut)
    else $error("output not driven low while select and start low");
  a_start_release: assert property (
    startRise && serialInSelect |-> ##[1:4] serialOutEnN)
    else $error("output not released after select mode start");
  a_select_release: assert property (
    csMode && convertStart && $rose(serialInSelect) |-> ##[1:5] serialOutEnN)
    else $error("output not released after select rise");
  a_bit_stable_high: assert property (
    serialClk && $past(serialClk) && !serialOutEnN && !$past(serialOutEnN)
    |-> $stable(serialOut))
    else $error("data changed while serial clock high");
  a_release_count: assert property (
    csMode && clkFall && fallCnt == 5'd16 |-> ##[1:5] serialOutEnN)
    else $error("output still driven after seventeenth fall");
  a_no_early_data: assert property (
    csMode && $fell(serialOutEnN) && fallCnt == 5'd0 |-> convCnt >= CONV_CYCLES)
    else $error("select mode output driven before conversion end");
  a_busy_bit_low: assert property (
    csMode && $fell(serialOutEnN) && fallCnt == 5'd0 && convCnt <= LATE |-> !serialOut)
    else $error("busy bit not low");
  a_chain_busy_high: assert property (
    !csMode && chainBusy && fallCnt == 5'h01 && convCnt == LATE // after mode-select fall
    |-> serialOut && !serialOutEnN)
    else $error("chain busy level missing at completion");
  a_chain_conv_low: assert property (
    !csMode && convertStart && fallCnt == 5'd0 && convCnt < CONV_CYCLES
    |-> !serialOutEnN && !serialOut)
    else $error("chain output not low during conversion");
  cover property (csMode && clkFall && fallCnt == 5'd15);
  cover property (!csMode && chainBusy && $rose(serialOut));
  cover property (csMode && $fell(serialOutEnN) && convCnt <= LATE);
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// testbench joining the converter end and the host end over the link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int CONV_NS = 600;
  logic                      ref_clk = 1'b0;
  logic                      rstn = 1'b0;
  logic                      start = 1'b0;
  sar_readout_pkg::mode_type modeSel = sar_readout_pkg::MODE_CS_PLAIN;
  logic [15:0]               sampleValue = 16'h0000;
  logic                      ready;
  logic                      wordValid;
  logic                      frameDone;
  logic                      corePowered;
  logic                      resultReady;
  logic [15:0]               wordData;
  logic                      prevClk = 1'b0;
  int                        errors = 0;
  int                        checked = 0;
  int                        cycles = 0;
  int                        falls = 0;
  sar_readout_pkg::mode_type modes [4] = '{sar_readout_pkg::MODE_CS_PLAIN,
    sar_readout_pkg::MODE_CS_BUSY, sar_readout_pkg::MODE_CHAIN_PLAIN,
    sar_readout_pkg::MODE_CHAIN_BUSY};
  sar_link_if link ();
  sar_adc_end #(.CONV_NS(CONV_NS), .CHAIN_HEAD(1'b1)) sar_adc_end_inst (
    .ref_clk(ref_clk), .rstn(rstn), .link(link), .sampleValue(sampleValue),
    .corePowered(corePowered), .resultReady(resultReady));
  sar_host_end #(.CHAIN_LEN(1)) sar_host_end_inst (
    .ref_clk(ref_clk), .rstn(rstn), .link(link), .start(start), .modeSel(modeSel),
    .ready(ready), .wordData(wordData), .wordValid(wordValid), .frameDone(frameDone));
  sar_readout_props #(.CONV_CYCLES((CONV_NS + 7) / 8)) sar_readout_props_inst (
    .ref_clk(ref_clk), .rstn(rstn), .convertStart(link.convertStart),
    .serialInSelect(link.serialInSelect), .serialClk(link.serialClk),
    .serialOut(link.serialOut), .serialOutEnN(link.serialOutEnN));
  // reference clock
  always #4 ref_clk = ~ref_clk;
  // serial clock fall counter and run ceiling
  always @(posedge ref_clk) begin
    prevClk <= link.serialClk;
    if (prevClk && !link.serialClk) falls <= falls + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      conclude();
    end
  end
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // advance one cycle and settle
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  // issue one host command once ready
  task automatic kick(input sar_readout_pkg::mode_type m, input logic [15:0] v);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    sampleValue = v;
    modeSel = m;
    start = 1'b1;
    tick();
    start = 1'b0;
  endtask
  // one whole conversion and readout with its checks
  task automatic run(input sar_readout_pkg::mode_type m, input logic [15:0] v);
    int   base;
    int   n;
    logic busy;
    logic seenPower;
    busy = (m == sar_readout_pkg::MODE_CS_BUSY) || (m == sar_readout_pkg::MODE_CHAIN_BUSY);
    kick(m, v);
    base = falls;
    seenPower = 1'b0;
    n = 0;
    while (wordValid !== 1'b1 && n < 1000) begin
      // count readback falls only, not the fall that ends chain mode selection
      if (corePowered === 1'b1) begin
        seenPower = 1'b1;
        base = falls;
      end
      tick();
      n++;
    end
    chk("word", v, wordData);
    n = 0;
    while (frameDone !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    tick();
    chk("falls", busy ? 16'h0011 : 16'h0010, 16'(falls - base));
    chk("powered", 16'h0001, {15'h0000, seenPower});
    chk("core idle", 16'h0000, {15'h0000, corePowered});
    chk("result held", 16'h0001, {15'h0000, resultReady});
    repeat (5) tick();
    if (m == sar_readout_pkg::MODE_CS_PLAIN || m == sar_readout_pkg::MODE_CS_BUSY) begin
      chk("released", 16'h0001, {15'h0000, link.serialOutEnN});
    end
    $display("test mode %h word %h done", m, v);
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    foreach (modes[i]) run(modes[i], 16'h8001 ^ (16'h3c5a << i));
    run(sar_readout_pkg::MODE_CHAIN_BUSY, 16'h0001);
    run(sar_readout_pkg::MODE_CS_BUSY, 16'hfffe);
    run(sar_readout_pkg::MODE_CHAIN_PLAIN, 16'hffff);
    run(sar_readout_pkg::MODE_CS_PLAIN, 16'h0000);
    // reset in the middle of a conversion, then resume
    kick(sar_readout_pkg::MODE_CS_BUSY, 16'h1234);
    repeat (30) tick();
    rstn = 1'b0;
    repeat (6) tick();
    rstn = 1'b1;
    tick();
    chk("ready after reset", 16'h0001, {15'h0000, ready});
    chk("released after reset", 16'h0001, {15'h0000, link.serialOutEnN});
    $display("test reset in mid conversion done");
    run(sar_readout_pkg::MODE_CS_BUSY, 16'h1234);
    run(sar_readout_pkg::MODE_CHAIN_PLAIN, 16'h4321);
    conclude();
  end
endmodule
`default_nettype wire
